// ==== logic/oepc_ctrl.sv ====
// Host-side programmer and reader for a 128K x 8 OTP memory
`timescale 1ns/10ps
`default_nettype none
`include "oepc_consts.svh"
module oepc_ctrl #(
	parameter int PULSE_CYC = `OEPC_PULSE_CYC,
	parameter int MAX_PULSES = `OEPC_MAX_PULSES,
	parameter logic [16:0] LAST_ADDR = 17'h1FFFF
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic start_prog,
	input wire logic start_read,
	input wire logic start_id,
	input wire logic [16:0] req_addr,
	input wire logic id_byte_sel,
	input wire logic [7:0] prog_data,
	output logic prog_data_req,
	output logic [16:0] mem_addr,
	output logic [7:0] dq_out,
	output logic dq_oe_n,
	input wire logic [7:0] dq_in,
	output logic ce_n,
	output logic oe_n,
	output logic program_pulse_n,
	output logic vpp_prog_level,
	output logic identify_high_voltage_level,
	output logic busy,
	output logic done,
	output logic fail,
	output logic [16:0] fail_addr,
	output logic [7:0] read_data,
	output logic read_valid,
	output logic id_parity_ok
);
	oepc_pkg::oepc_state_s s_r, s_nxt;

	// Odd parity over all eight bits
	function automatic logic odd_par(input logic [7:0] b);
		odd_par = ^b;
	endfunction

	function automatic logic [15:0] acc_cnt();
		acc_cnt = 16'(`OEPC_ACC_CYC + `OEPC_SETUP_CYC);
	endfunction

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.rv = 1'b0;
		// Pin data crosses from the device: three stages, second and third must agree
		s_nxt.sync1 = dq_in;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.sync3 = s_r.sync2;
		s_nxt.done = 1'b0;
		if (s_r.cnt != 16'h0000) begin
			s_nxt.cnt = s_r.cnt - 16'h0001;
		end
		unique case (s_r.st)
			oepc_pkg::ST_IDLE: begin
				s_nxt.ce_n = 1'b1;
				s_nxt.oe_n = 1'b1;
				s_nxt.pls_n = 1'b1;
				s_nxt.vpp_hi = 1'b0;
				s_nxt.idv_en = 1'b0;
				s_nxt.dq_oe_n = 1'b1;
				if (start_prog) begin
					s_nxt.busy = 1'b1;
					s_nxt.fail = 1'b0;
					s_nxt.addr = '0;
					s_nxt.pulses = '0;
					s_nxt.wdata = prog_data;
					s_nxt.vpp_hi = 1'b1;
					s_nxt.st = oepc_pkg::ST_SETUP;
					s_nxt.cnt = 16'(`OEPC_SETUP_CYC);
				end else if (start_id) begin
					s_nxt.busy = 1'b1;
					// Only the byte select line may be high here
					s_nxt.addr = '0;
					s_nxt.addr[`OEPC_SEL_BIT] = id_byte_sel;
					s_nxt.idv_en = 1'b1;
					s_nxt.ce_n = 1'b0;
					s_nxt.oe_n = 1'b0;
					s_nxt.cnt = acc_cnt();
					s_nxt.st = oepc_pkg::ST_ID;
				end else if (start_read) begin
					s_nxt.busy = 1'b1;
					s_nxt.addr = req_addr;
					s_nxt.ce_n = 1'b0;
					s_nxt.oe_n = 1'b0;
					s_nxt.cnt = acc_cnt();
					s_nxt.st = oepc_pkg::ST_READ;
				end
			end
			oepc_pkg::ST_SETUP: begin
				// Address, data and supply settle before the pulse
				s_nxt.ce_n = 1'b0;
				s_nxt.oe_n = 1'b1;
				s_nxt.dq_oe_n = 1'b0;
				if (s_r.cnt == 16'h0000 && s_r.dq_oe_n == 1'b0) begin
					s_nxt.pls_n = 1'b0;
					s_nxt.pulses = s_r.pulses + 5'h01;
					s_nxt.cnt = 16'(PULSE_CYC - 1);
					s_nxt.st = oepc_pkg::ST_PULSE;
				end
			end
			oepc_pkg::ST_PULSE: begin
				if (s_r.cnt == 16'h0000) begin
					s_nxt.pls_n = 1'b1;
					s_nxt.dq_oe_n = 1'b1;
					s_nxt.st = oepc_pkg::ST_VSET;
					s_nxt.cnt = 16'(`OEPC_SETUP_CYC);
				end
			end
			oepc_pkg::ST_VSET: begin
				// Release the bus before the device starts driving
				if (s_r.cnt == 16'h0000) begin
					s_nxt.oe_n = 1'b0;
					s_nxt.cnt = acc_cnt();
					s_nxt.st = oepc_pkg::ST_VCHK;
				end
			end
			oepc_pkg::ST_VCHK: begin
				if (s_r.cnt == 16'h0000 && s_r.sync2 == s_r.sync3) begin
					s_nxt.oe_n = 1'b1;
					if (s_r.sync3 == s_r.wdata) begin
						s_nxt.st = oepc_pkg::ST_NEXT;
					end else if (32'(s_r.pulses) >= MAX_PULSES) begin
						s_nxt.fail = 1'b1;
						s_nxt.fail_addr = s_r.addr;
						s_nxt.st = oepc_pkg::ST_DONE;
					end else begin
						s_nxt.st = oepc_pkg::ST_SETUP;
						s_nxt.cnt = 16'(`OEPC_SETUP_CYC);
					end
				end
			end
			oepc_pkg::ST_NEXT: begin
				s_nxt.pulses = '0;
				s_nxt.wdata = prog_data;
				if (s_r.addr == LAST_ADDR) begin
					// Final pass at normal supply
					s_nxt.vpp_hi = 1'b0;
					s_nxt.addr = '0;
					s_nxt.ce_n = 1'b0;
					s_nxt.oe_n = 1'b0;
					s_nxt.cnt = acc_cnt();
					s_nxt.st = oepc_pkg::ST_RSET;
				end else begin
					s_nxt.addr = s_r.addr + 17'h00001;
					s_nxt.cnt = 16'(`OEPC_SETUP_CYC);
					s_nxt.st = oepc_pkg::ST_SETUP;
				end
			end
			oepc_pkg::ST_RSET: begin
				if (s_r.cnt == 16'h0000 && s_r.sync2 == s_r.sync3) begin
					s_nxt.st = oepc_pkg::ST_RCHK;
				end
			end
			oepc_pkg::ST_RCHK: begin
				if (s_r.sync3 != s_r.wdata) begin
					s_nxt.fail = 1'b1;
					s_nxt.fail_addr = s_r.addr;
					s_nxt.st = oepc_pkg::ST_DONE;
				end else if (s_r.addr == LAST_ADDR) begin
					s_nxt.st = oepc_pkg::ST_DONE;
				end else begin
					s_nxt.addr = s_r.addr + 17'h00001;
					s_nxt.wdata = prog_data;
					s_nxt.cnt = acc_cnt();
					s_nxt.st = oepc_pkg::ST_RSET;
				end
			end
			oepc_pkg::ST_ID, oepc_pkg::ST_READ: begin
				if (s_r.cnt == 16'h0000 && s_r.sync2 == s_r.sync3) begin
					s_nxt.rdata = s_r.sync3;
					// Identifier bytes must have odd parity
					s_nxt.ok = (s_r.st == oepc_pkg::ST_ID) ? odd_par(s_r.sync3) : 1'b0;
					s_nxt.rv = 1'b1;
					s_nxt.st = oepc_pkg::ST_DONE;
				end
			end
			oepc_pkg::ST_DONE: begin
				s_nxt.ce_n = 1'b1;
				s_nxt.oe_n = 1'b1;
				s_nxt.pls_n = 1'b1;
				s_nxt.vpp_hi = 1'b0;
				s_nxt.idv_en = 1'b0;
				s_nxt.dq_oe_n = 1'b1;
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
				s_nxt.st = oepc_pkg::ST_IDLE;
			end
			default: begin
				s_nxt.st = oepc_pkg::ST_IDLE;
			end
		endcase
		// Registered copy of the address-step states keeps the pin a flop output
		s_nxt.req = (s_nxt.st == oepc_pkg::ST_NEXT) || (s_nxt.st == oepc_pkg::ST_RCHK);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
			s_r.st <= oepc_pkg::ST_IDLE;
			s_r.ce_n <= 1'b1;
			s_r.oe_n <= 1'b1;
			s_r.pls_n <= 1'b1;
			s_r.dq_oe_n <= 1'b1;
			s_r.wdata <= `OEPC_ERASED_BYTE;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign mem_addr = s_r.addr;
	assign dq_out = s_r.wdata;
	assign dq_oe_n = s_r.dq_oe_n;
	assign ce_n = s_r.ce_n;
	assign oe_n = s_r.oe_n;
	assign program_pulse_n = s_r.pls_n;
	assign vpp_prog_level = s_r.vpp_hi;
	assign identify_high_voltage_level = s_r.idv_en;
	assign busy = s_r.busy;
	assign done = s_r.done;
	assign fail = s_r.fail;
	assign fail_addr = s_r.fail_addr;
	assign read_data = s_r.rdata;
	assign read_valid = s_r.rv;
	assign id_parity_ok = s_r.ok;
	// Asks the source for the next byte whenever the address steps; the byte for address 0 is taken at start_prog unasked
	assign prog_data_req = s_r.req;
endmodule
`default_nettype wire

// ==== shared/oepc_consts.svh ====
// Constants for the one-time-programmable memory programming controller
`ifndef OEPC_CONSTS_SVH
`define OEPC_CONSTS_SVH
`define OEPC_CLK_MHZ 10
`define OEPC_PULSE_US 100
`define OEPC_PULSE_CYC (`OEPC_PULSE_US * `OEPC_CLK_MHZ)
`define OEPC_MAX_PULSES 25
`define OEPC_ACC_NS 150
`define OEPC_ACC_CYC ((`OEPC_ACC_NS * `OEPC_CLK_MHZ + 999) / 1000)
`define OEPC_SETUP_CYC 1
`define OEPC_ERASED_BYTE 8'hFF
`define OEPC_ADDR_W 17
`define OEPC_DATA_W 8
`define OEPC_TRIG_BIT 9
`define OEPC_SEL_BIT 0
`endif

// ==== shared/oepc_pkg.sv ====
// Types for the programming controller
`default_nettype none
package oepc_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_SETUP, ST_PULSE, ST_VSET, ST_VCHK, ST_NEXT,
		ST_RSET, ST_RCHK, ST_ID, ST_READ, ST_DONE
	} oepc_state_e;
	typedef struct packed {
		oepc_state_e st;
		logic [16:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic [15:0] cnt;
		logic [4:0] pulses;
		logic [1:0] sync_ph;
		logic ce_n;
		logic oe_n;
		logic pls_n;
		logic vpp_hi;
		logic idv_en;
		logic dq_oe_n;
		logic busy;
		logic done;
		logic fail;
		logic ok;
		logic [16:0] fail_addr;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] sync3;
		logic rv;
		logic req;
	} oepc_state_s;
endpackage
`default_nettype wire

// ==== verif/oepc_mem_model.sv ====
// Pin-level model of the OTP memory
`timescale 1ns/10ps
`default_nettype none
module oepc_mem_model #(
	// Arbitrary identifier codes, odd parity
	parameter logic [7:0] MAN_ID = 8'h8A,
	parameter logic [7:0] DEV_ID = 8'h15
) (
	input wire logic clk,
	input wire logic [16:0] mem_addr,
	input wire logic [7:0] dq_out,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic program_pulse_n,
	input wire logic vpp_prog_level,
	input wire logic identify_high_voltage_level,
	input wire logic [5:0] need,
	output logic [7:0] dq_in
);
	logic [7:0] mem [4] = '{default: 8'hFF};
	logic [7:0] dv;
	logic [7:0] lastv = 8'h00;
	int pcnt = 0;
	wire logic drv = !ce_n && !oe_n;
	// Only two address bits kept: the bench uses four locations
	always @(mem_addr or posedge vpp_prog_level) pcnt = 0;
	// Stubborn cell: holds only after need pulses
	always @(negedge program_pulse_n) begin
		if (!ce_n && vpp_prog_level) begin
			pcnt = pcnt + 1;
			if (pcnt >= need) mem[mem_addr[1:0]] &= dq_out;
		end
	end
	assign dv = identify_high_voltage_level ? (mem_addr[0] ? DEV_ID : MAN_ID)
		: mem[mem_addr[1:0]];
	// Released lines show the inverse, never a held byte
	always @(posedge clk) if (drv) lastv <= dv;
	assign dq_in = drv ? dv : ~lastv;
endmodule
`default_nettype wire

// ==== verif/oepc_ctrl_chk.sv ====
// Pin-side assertions for the OTP programming controller
`timescale 1ns/10ps
`default_nettype none
module oepc_ctrl_chk #(
	parameter int PULSE_CYC = 1000,
	parameter int MAX_PULSES = 25
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [16:0] mem_addr,
	input wire logic [7:0] dq_out,
	input wire logic dq_oe_n,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic program_pulse_n,
	input wire logic vpp_prog_level,
	input wire logic identify_high_voltage_level
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	int lowc;
	int pc;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lowc <= 0;
			pc <= 0;
		end else begin
			lowc <= program_pulse_n ? 0 : lowc + 1;
			pc <= $changed(mem_addr) ? 0 : pc + int'($fell(program_pulse_n));
		end
	end
	sequence s_pulse_start;
		$fell(program_pulse_n);
	endsequence
	sequence s_pulse_end;
		$rose(program_pulse_n);
	endsequence
	chk_pulse_qual: assert property (s_pulse_start |-> vpp_prog_level && !ce_n && oe_n)
		else $error("pulse outside program mode");
	chk_pulse_width: assert property (s_pulse_end |-> lowc == PULSE_CYC)
		else $error("pulse width wrong");
	chk_pulse_data: assert property (!program_pulse_n |-> !dq_oe_n && $stable(dq_out)
		&& $stable(mem_addr)) else $error("lines moved during pulse");
	chk_pulse_limit: assert property (pc <= MAX_PULSES)
		else $error("too many pulses");
	chk_verify_mode: assert property (!oe_n && vpp_prog_level |-> !ce_n && program_pulse_n)
		else $error("bad verify mode");
	chk_gate_drive: assert property (!oe_n |-> dq_oe_n)
		else $error("bus contention");
	chk_id_lines: assert property (identify_high_voltage_level |-> !vpp_prog_level
		&& mem_addr[16:1] == 16'h0000) else $error("identify lines wrong");
	chk_read_strobe: assert property ($fell(oe_n) |-> !ce_n)
		else $error("gate without select");
endmodule
`default_nettype wire

// ==== verif/oepc_ctrl_tb.sv ====
// Self-checking bench for the OTP programming controller
`timescale 1ns/10ps
`default_nettype none
module oepc_ctrl_tb;
	localparam int N = 4;
	localparam logic [7:0] MAN = 8'h8A;
	localparam logic [7:0] DEV = 8'h15;
	logic clk, rstn, start_prog, start_read, start_id, id_byte_sel, prog_data_req, dq_oe_n;
	logic ce_n, oe_n, program_pulse_n, vpp_prog_level, identify_high_voltage_level;
	logic busy, done, fail, read_valid, id_parity_ok;
	logic [16:0] req_addr, mem_addr, fail_addr;
	logic [7:0] prog_data, dq_out, dq_in, read_data;
	logic [7:0] pv [N];
	logic [7:0] ref_m [N];
	logic [5:0] need;
	int k, mismatches, n_compared;
	logic clk_en;
	// Random freezing only while a read runs; programming timing stays exact
	bit frz;
	oepc_ctrl #(.PULSE_CYC(4), .LAST_ADDR(17'h00003)) dut_u (.*);
	oepc_mem_model #(.MAN_ID(MAN), .DEV_ID(DEV)) mem_u (.*);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Next byte must already stand in the request cycle
	always @(negedge clk) prog_data <= pv[(k + int'(prog_data_req === 1'b1)) % N];
	always @(posedge clk) if (prog_data_req === 1'b1) k <= k + 1;
	task automatic cmp_v(input string nm, input logic [16:0] e, input logic [16:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_f(input string nm, input logic e, input logic g);
		cmp_v(nm, 17'(e), 17'(g));
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic op(input logic [2:0] s, input logic [16:0] a, input logic b);
		int n;
		logic rv;
		n = 0;
		rv = 1'b0;
		clk_en = 1'b1;
		{start_prog, start_id, start_read} = s;
		req_addr = a;
		id_byte_sel = b;
		@(negedge clk);
		{start_prog, start_id, start_read} = 3'b000;
		cmp_f("busy", 1'b1, busy);
		while (done !== 1'b1 && n < 9000) begin
			rv = read_valid;
			@(negedge clk);
			n++;
			clk_en = (frz && done !== 1'b1) ? 1'($urandom) : 1'b1;
		end
		if (n == 9000) begin
			$display("Error done expected 1 seen %b", done);
			mismatches++;
			test_done;
		end
		cmp_f("read_valid", s != 3'b100, rv);
		cmp_f("busy", 1'b0, busy);
		repeat (2) @(negedge clk);
	endtask
	task automatic rd(input logic [16:0] a);
		op(3'b001, a, 1'b0);
		cmp_v("read_data", 17'(ref_m[a[1:0]]), 17'(read_data));
		cmp_f("id_parity_ok", 1'b0, id_parity_ok);
	endtask
	task automatic prog(input logic [5:0] nd);
		logic fl;
		logic [16:0] ef;
		fl = 1'b0;
		ef = 17'h00000;
		need = nd;
		k = 0;
		@(negedge clk);
		for (int a = 0; a < N; a++) begin
			if (!fl && nd <= 25) ref_m[a] = ref_m[a] & pv[a];
			if (!fl && ref_m[a] !== pv[a]) begin
				fl = 1'b1;
				ef = 17'(a);
			end
		end
		op(3'b100, 17'h00000, 1'b0);
		cmp_f("fail", fl, fail);
		if (fl) cmp_v("fail_addr", ef, fail_addr);
		$display("prog test done, pulses needed %0d", nd);
	endtask
	initial begin
		{rstn, start_prog, start_read, start_id, id_byte_sel} = 5'b00000;
		req_addr = 17'h00000;
		prog_data = 8'h00;
		need = 6'h01;
		clk_en = 1'b1;
		frz = 1'b0;
		k = 0;
		mismatches = 0;
		n_compared = 0;
		void'($urandom(32'h7C2E2373));
		foreach (pv[a]) begin
			ref_m[a] = 8'hFF;
			pv[a] = 8'h00;
		end
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		rd(17'h00002);
		$display("erased read test done");
		foreach (pv[a]) pv[a] = 8'($urandom);
		prog(6'h01);
		foreach (pv[a]) pv[a] = ref_m[a] & 8'($urandom);
		prog(6'h03);
		foreach (pv[a]) pv[a] = ref_m[a] & 8'($urandom);
		prog(6'h19);
		foreach (pv[a]) pv[a] = ~ref_m[a];
		prog(6'h1A);
		for (int b = 0; b < 2; b++) begin
			op(3'b010, 17'h00000, b[0]);
			cmp_v("id_byte", 17'(b ? DEV : MAN), 17'(read_data));
			cmp_f("id_parity_ok", 1'b1, id_parity_ok);
		end
		$display("identify test done");
		frz = 1'b1;
		repeat (6) rd(17'($urandom));
		$display("random read test done");
		test_done;
	end
	initial begin
		#6000000;
		$display("Error watchdog expected finish seen timeout");
		mismatches++;
		test_done;
	end
endmodule
bind oepc_ctrl oepc_ctrl_chk #(.PULSE_CYC(PULSE_CYC), .MAX_PULSES(MAX_PULSES)) chk_u (.*);
`default_nettype wire
